/* File: cpu_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model #(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk,
    output logic                   rom_wr,
    output logic                   rom_rd,
    output logic      [ADDR_W-1:0] rom_addr,
    output logic      [7:0]        rom_wdata,
    input  wire logic [7:0]        rom_rdata,
    input  wire logic              rom_rvalid
);
    initial {rom_wr, rom_rd, rom_addr, rom_wdata} = '0;

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        rom_wr    <= 1'b1;
        rom_addr  <= a;
        rom_wdata <= d;
        @(posedge clk);
        rom_wr    <= 1'b0;
        // Released lines carry junk, not the last value
        rom_addr  <= ~a;
        rom_wdata <= ~d;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        rom_rd   <= 1'b1;
        rom_addr <= a;
        @(posedge clk);
        rom_rd   <= 1'b0;
        rom_addr <= ~a;
        @(posedge clk);
        #1;
        v = rom_rvalid;
        d = rom_rdata;
    endtask
endmodule
`default_nettype wire

/* File: flash_cell_array.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_cell_array #(
    parameter int ADDR_W = 11
) (
    input  wire logic              clk,
    input  wire logic              wr_en,
    input  wire logic              wr_erase,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [7:0]        wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [7:0]        rd_data
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    // ------
    // Cell behaviour
    // ------
    // Programming only clears bits; erase is the sole way back to ones
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            if (wr_erase)
                mem[wr_addr] <= 8'hFF;
            else
                mem[wr_addr] <= mem[wr_addr] & wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

/* File: flash_rewrite_command_sequencer.sv */
// Functional notes
// (RULE1) FFh write enters array-read mode
// (RULE2) Array-read mode after reset release
// (RULE3) 70h write enters status-read mode
// (RULE4) Status-read holds until array-read command
// (RULE5) Control flags mirror status register bits
// (RULE6) 50h clears both error flags
// (RULE7) 40h then data starts auto-program
// (RULE8) Ready low during programming, high after
// (RULE9) Program error flag shows program result
// (RULE10) 20h then D0h starts block erase
// (RULE11) Ready low during erasure, high after
// (RULE12) Erase error flag shows erase result; code just clears it when erase completes
// (RULE13) Block 0 needs unlock and no lock
// (RULE14) Block 1 refused while its lock set
// (RULE15) RAM mode: status-read when programming starts
// (RULE16) RAM mode: status-read when erasure starts
// (RULE17) ROM mode selected after enable already set
// (RULE18) ROM mode: host never sends status-read
// (RULE19) ROM mode: host spares rewrite code
// (RULE20) Host never reprograms byte before erase
// (RULE21) RAM mode: interrupts allowed during operation
// (RULE22) Sequence errors set both error flags
// (RULE23) FFh as erase confirm cancels erase
// (RULE24) Commands decoded only while rewrite enabled
// (RULE25) Cycle-count parameters set operation durations
`timescale 1ns/1ns
`default_nettype none
module flash_rewrite_command_sequencer
    import flash_seq_pkg::*;
#(
    parameter int ADDR_W       = flash_seq_pkg::ADDR_W_DEF,
    parameter int BLK_W        = flash_seq_pkg::BLK_W_DEF,
    parameter int NUM_BLK      = flash_seq_pkg::NUM_BLK_DEF,
    parameter int PROG_CYCLES  = flash_seq_pkg::PROG_CYCLES_DEF,
    parameter int ERASE_CYCLES = flash_seq_pkg::ERASE_CYCLES_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              rom_wr,
    input  wire logic              rom_rd,
    input  wire logic [ADDR_W-1:0] rom_addr,
    input  wire logic [7:0]        rom_wdata,
    output logic      [7:0]        rom_rdata,
    output logic                   rom_rvalid,
    input  wire logic              cpu_rewrite_enable,
    input  wire logic              low_block_master_unlock,
    input  wire logic              rom_resident_mode_select,
    input  wire logic              block_zero_lock,
    input  wire logic              block_one_lock,
    output logic                   flash_ready_flag,
    output logic                   program_error_flag,
    output logic                   erase_error_flag,
    output logic                   status_program_error,
    output logic                   status_erase_error,
    output logic                   status_read_active,
    output logic                   ram_resident_rewrite_mode,
    output logic                   rom_resident_rewrite_mode,
    output logic                   maskable_irq_allowed
);
    import flash_seq_pkg::*;

    localparam int ARR_W = $clog2(NUM_BLK) + BLK_W;
    localparam int BI_W  = ADDR_W - BLK_W;

    typedef struct packed {
        seq_state_t        st;
        read_mode_t        rmode;
        logic              ready;
        logic              perr;
        logic              eerr;
        logic              rom_mode;
        logic              ram_mode;
        logic              en_prev;
        logic              sel_prev;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
        logic [BLK_W:0]    ptr;
        logic              wr_en;
        logic              wr_erase;
        logic [ADDR_W-1:0] wr_addr;
        logic              tstart;
        logic [CNT_W-1:0]  tcycles;
        logic [7:0]        rd_data;
        logic [RD_LATENCY-1:0] rd_pipe;
        logic              irq_ok;
    } state_t;

    state_t q;
    state_t d;

    logic [7:0]        arr_rd;
    logic [ADDR_W-1:0] arr_rd_addr;
    logic              t_busy;
    logic              op_busy;
    logic [BI_W-1:0]   tgt_blk;
    logic              tgt_ok;
    logic [7:0]        status_byte;

    // ------
    // Target block check
    // ------
    assign tgt_blk = rom_addr[ADDR_W-1:BLK_W];

    always_comb
    begin
        tgt_ok = 1'b1;
        if (tgt_blk >= BI_W'(NUM_BLK))
            tgt_ok = 1'b0;
        // (RULE13) block zero gate
        else if (tgt_blk == BI_W'(0))
            tgt_ok = low_block_master_unlock & ~block_zero_lock;
        // (RULE14) block one gate
        else if (tgt_blk == BI_W'(1))
            tgt_ok = ~block_one_lock;
    end

    // (RULE5) shared status view
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[SR_READY_BIT] = q.ready;
        status_byte[SR_ERASE_ERR_BIT] = q.eerr;
        status_byte[SR_PROG_ERR_BIT] = q.perr;
    end

    assign op_busy = (q.st == ST_PROG_RUN) || (q.st == ST_ERASE_RUN)
                  || (q.st == ST_VERIFY_WAIT) || (q.st == ST_VERIFY);
    // CPU reads during an operation see unrelated cells; software must not read
    assign arr_rd_addr = op_busy ? q.addr : rom_addr;

    // ------
    // Sequencer
    // ------
    always_comb
    begin
        d = q;
        d.wr_en = 1'b0;
        d.tstart = 1'b0;
        d.en_prev = cpu_rewrite_enable;
        d.sel_prev = rom_resident_mode_select;

        // (RULE17) ROM mode only after enable already set
        if (!cpu_rewrite_enable || !rom_resident_mode_select)
            d.rom_mode = 1'b0;
        else if (!q.sel_prev && q.en_prev)
            d.rom_mode = 1'b1;
        d.ram_mode = cpu_rewrite_enable & ~d.rom_mode;

        case (q.st)
            ST_IDLE:
            begin
                // (RULE24) decode gated by rewrite enable
                if (rom_wr && cpu_rewrite_enable)
                begin
                    case (rom_wdata)
                        // (RULE1) array-read entry
                        CMD_READ_ARRAY:
                            d.rmode = RM_ARRAY;
                        // (RULE3) status-read entry
                        CMD_READ_STATUS:
                            d.rmode = RM_STATUS;
                        // (RULE6) clear both errors
                        CMD_CLEAR_STATUS:
                        begin
                            d.perr = 1'b0;
                            d.eerr = 1'b0;
                        end
                        CMD_PROGRAM:
                            d.st = ST_PROG_WAIT;
                        CMD_ERASE:
                            d.st = ST_ERASE_WAIT;
                        // (RULE22) malformed command
                        default:
                        begin
                            d.perr = 1'b1;
                            d.eerr = 1'b1;
                        end
                    endcase
                end
            end

            ST_PROG_WAIT:
            begin
                if (!cpu_rewrite_enable)
                    d.st = ST_IDLE;
                else if (rom_wr)
                begin
                    if (!tgt_ok)
                    begin
                        // (RULE22) locked or unmapped program
                        d.perr = 1'b1;
                        d.eerr = 1'b1;
                        d.st = ST_IDLE;
                    end
                    else
                    begin
                        // (RULE7) start auto-program
                        d.addr = rom_addr;
                        d.data = rom_wdata;
                        d.wr_en = 1'b1;
                        d.wr_erase = 1'b0;
                        d.wr_addr = rom_addr;
                        d.tstart = 1'b1;
                        d.tcycles = CNT_W'(PROG_CYCLES);
                        // (RULE8) busy while programming
                        d.ready = 1'b0;
                        // (RULE15) status view in RAM mode
                        if (!q.rom_mode)
                            d.rmode = RM_STATUS;
                        d.st = ST_PROG_RUN;
                    end
                end
            end

            ST_ERASE_WAIT:
            begin
                if (!cpu_rewrite_enable)
                    d.st = ST_IDLE;
                else if (rom_wr)
                begin
                    d.st = ST_IDLE;
                    // (RULE23) cancel erase, back to array
                    if (rom_wdata == CMD_READ_ARRAY)
                        d.rmode = RM_ARRAY;
                    else if (rom_wdata != CMD_ERASE_CONFIRM || !tgt_ok)
                    begin
                        // (RULE22) bad confirm or target
                        d.perr = 1'b1;
                        d.eerr = 1'b1;
                    end
                    else
                    begin
                        // (RULE10) start block erase
                        d.addr = rom_addr;
                        d.ptr = '0;
                        d.tstart = 1'b1;
                        d.tcycles = CNT_W'(ERASE_CYCLES);
                        // (RULE11) busy while erasing
                        d.ready = 1'b0;
                        // (RULE16) status view in RAM mode
                        if (!q.rom_mode)
                            d.rmode = RM_STATUS;
                        d.st = ST_ERASE_RUN;
                    end
                end
            end

            ST_PROG_RUN:
            begin
                // (RULE25) full programming time first
                if (!t_busy && !q.tstart)
                    d.st = ST_VERIFY_WAIT;
            end

            ST_ERASE_RUN:
            begin
                // Walk one cell per cycle to keep the array single-ported
                if (!q.ptr[BLK_W])
                begin
                    d.wr_en = 1'b1;
                    d.wr_erase = 1'b1;
                    d.wr_addr = {q.addr[ADDR_W-1:BLK_W], q.ptr[BLK_W-1:0]};
                    d.ptr = q.ptr + 1'b1;
                end
                // (RULE25) both walk and time complete
                else if (!t_busy && !q.tstart)
                begin
                    // (RULE12) erase error cleared at completion; the walk is not read back
                    d.eerr = 1'b0;
                    // (RULE11) ready again
                    d.ready = 1'b1;
                    d.st = ST_IDLE;
                end
            end

            ST_VERIFY_WAIT:
                d.st = ST_VERIFY;

            ST_VERIFY:
            begin
                // (RULE9) read back decides result
                d.perr = (arr_rd != q.data);
                // (RULE8) ready again
                d.ready = 1'b1;
                d.st = ST_IDLE;
            end

            default:
                d.st = ST_IDLE;
        endcase

        // (RULE21) interrupts held off only in ROM mode
        d.irq_ok = ~(d.rom_mode & (d.st != ST_IDLE) & ~d.ready);

        // Read pipe: array cell captured, then mode select
        d.rd_pipe = {q.rd_pipe[RD_LATENCY-2:0], rom_rd};
        if (q.rd_pipe[0])
        begin
            // (RULE4) status returned while status mode held
            if (q.rmode == RM_STATUS)
                d.rd_data = status_byte;
            else
                d.rd_data = arr_rd;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= '0;
            // (RULE2) array-read after reset
            q.rmode <= RM_ARRAY;
            q.st <= ST_IDLE;
            q.ready <= READY_RST;
            q.perr <= ERR_RST;
            q.eerr <= ERR_RST;
            q.irq_ok <= 1'b1;
        end
        else
            q <= d;
    end

    // ------
    // Array and timer
    // ------
    flash_cell_array #(
        .ADDR_W (ARR_W)
    ) u_array (
        .clk      (clk),
        .wr_en    (q.wr_en),
        .wr_erase (q.wr_erase),
        .wr_addr  (q.wr_addr[ARR_W-1:0]),
        .wr_data  (q.data),
        .rd_addr  (arr_rd_addr[ARR_W-1:0]),
        .rd_data  (arr_rd)
    );

    op_timer #(
        .CNT_W (CNT_W)
    ) u_timer (
        .clk    (clk),
        .rst    (rst),
        .start  (q.tstart),
        .cycles (q.tcycles),
        .busy   (t_busy)
    );

    // ------
    // Outputs
    // ------
    assign rom_rdata = q.rd_data;
    assign rom_rvalid = q.rd_pipe[RD_LATENCY-1];
    assign flash_ready_flag = q.ready;
    // (RULE5) same flops feed both views
    assign program_error_flag = q.perr;
    assign erase_error_flag = q.eerr;
    assign status_program_error = q.perr;
    assign status_erase_error = q.eerr;
    assign status_read_active = (q.rmode == RM_STATUS);
    assign ram_resident_rewrite_mode = q.ram_mode;
    assign rom_resident_rewrite_mode = q.rom_mode;
    assign maskable_irq_allowed = q.irq_ok;
endmodule
`default_nettype wire

/* File: flash_rewrite_command_sequencer_props.sv */
`timescale 1ns/1ns
`default_nettype none
module seq_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        rom_wr,
    input wire logic        rom_rd,
    input wire logic [11:0] rom_addr,
    input wire logic [7:0]  rom_wdata,
    input wire logic        rom_rvalid,
    input wire logic        cpu_rewrite_enable,
    input wire logic        low_block_master_unlock,
    input wire logic        rom_resident_mode_select,
    input wire logic        block_zero_lock,
    input wire logic        block_one_lock,
    input wire logic        flash_ready_flag,
    input wire logic        program_error_flag,
    input wire logic        erase_error_flag,
    input wire logic        status_program_error,
    input wire logic        status_erase_error,
    input wire logic        status_read_active,
    input wire logic        ram_resident_rewrite_mode,
    input wire logic        maskable_irq_allowed,
    input wire logic        rom_resident_rewrite_mode
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    // ----
    // Command byte tracking
    // ----
    logic       first_q;
    logic [7:0] kind_q;
    logic       acc, cmd, blk_ok, go, bad;

    always_comb
    begin
        acc    = rom_wr && cpu_rewrite_enable && flash_ready_flag;
        cmd    = acc && first_q;
        blk_ok = (rom_addr[11:10] == 2'h0) ? low_block_master_unlock && !block_zero_lock
               : (rom_addr[11:10] == 2'h1) && !block_one_lock;
        go     = acc && !first_q && blk_ok && (kind_q == 8'h40 || rom_wdata == 8'hD0);
        bad    = acc && !first_q && !blk_ok && rom_wdata != 8'hFF;
    end

    always_ff @(posedge clk)
    begin
        if (rst || !cpu_rewrite_enable)
            first_q <= 1'b1;
        else if (acc)
            first_q <= !first_q || (rom_wdata != 8'h40 && rom_wdata != 8'h20);
        if (acc && first_q)
            kind_q <= rom_wdata;
    end

    property p_rd_lat;
        rom_rd |-> ##2 rom_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("late read answer");
    property p_array;
        cmd && rom_wdata == 8'hFF |=> !status_read_active;
    endproperty
    a_array: assert property (p_array)
        else $error("array mode missed");
    property p_status;
        cmd && rom_wdata == 8'h70 |=> status_read_active;
    endproperty
    a_status: assert property (p_status)
        else $error("status mode missed");
    property p_mirror;
        program_error_flag == status_program_error && erase_error_flag == status_erase_error;
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("mirror differs");
    property p_clear;
        cmd && rom_wdata == 8'h50 |=> !program_error_flag && !erase_error_flag;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear missed");
    property p_start;
        go |-> ##[1:2] !flash_ready_flag;
    endproperty
    a_start: assert property (p_start)
        else $error("no start");
    property p_refuse;
        bad |-> ##[1:2] (program_error_flag && erase_error_flag);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("refusal flags missed");
    property p_busy_min;
        $fell(flash_ready_flag) |-> (!flash_ready_flag) [*8];
    endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("early ready");
    property p_ram_stat;
        $fell(flash_ready_flag) && ram_resident_rewrite_mode |-> status_read_active;
    endproperty
    a_ram_stat: assert property (p_ram_stat)
        else $error("no status at start");
    property p_irq;
        !flash_ready_flag && ram_resident_rewrite_mode |-> maskable_irq_allowed;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq held off");
    property p_rom_mode;
        $rose(rom_resident_mode_select) && $past(cpu_rewrite_enable) && cpu_rewrite_enable
            |=> rom_resident_rewrite_mode;
    endproperty
    a_rom_mode: assert property (p_rom_mode)
        else $error("no rom mode");

    c_go: cover property (go);
    c_bad: cover property (bad);
    c_rom: cover property ($rose(rom_resident_rewrite_mode));
endmodule

bind flash_rewrite_command_sequencer seq_props props (
    .clk, .rst, .rom_wr, .rom_rd, .rom_addr, .rom_wdata, .rom_rvalid, .cpu_rewrite_enable,
    .low_block_master_unlock, .rom_resident_mode_select, .block_zero_lock, .block_one_lock,
    .flash_ready_flag, .program_error_flag, .erase_error_flag, .status_program_error,
    .status_erase_error, .status_read_active, .ram_resident_rewrite_mode,
    .maskable_irq_allowed, .rom_resident_rewrite_mode
);
`default_nettype wire

/* File: flash_rewrite_command_sequencer_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_rewrite_command_sequencer_tb_top;
    import flash_seq_pkg::*;
    logic        clk, rst, rom_wr, rom_rd, rom_rvalid;
    logic [11:0] rom_addr;
    logic [7:0]  rom_wdata, rom_rdata;
    logic        cpu_rewrite_enable, low_block_master_unlock, rom_resident_mode_select;
    logic        block_zero_lock, block_one_lock, flash_ready_flag, maskable_irq_allowed;
    logic        program_error_flag, erase_error_flag, status_program_error;
    logic        status_erase_error, status_read_active;
    logic        ram_resident_rewrite_mode, rom_resident_rewrite_mode;
    int          mismatches, checked, a;
    logic [7:0]  m_mem [int];
    logic        m_stat, m_perr, m_eerr;
    int          cad [5]  = '{12'h456, 12'h010, 12'h010, 12'h810, 12'h500};
    logic [7:0]  ccmd [5] = '{8'h40, 8'h40, 8'h20, 8'h40, 8'h20};
    logic [7:0]  cdat [5] = '{8'h0F, 8'h0F, 8'hD0, 8'h0F, 8'h33};
    logic [2:0]  ccfg [5] = '{3'h5, 3'h0, 3'h6, 3'h4, 3'h4};

    flash_rewrite_command_sequencer #(.PROG_CYCLES(20), .ERASE_CYCLES(1100)) dut (
        .clk, .rst, .rom_wr, .rom_rd, .rom_addr, .rom_wdata, .rom_rdata, .rom_rvalid,
        .cpu_rewrite_enable, .low_block_master_unlock, .rom_resident_mode_select,
        .block_zero_lock, .block_one_lock, .flash_ready_flag, .program_error_flag,
        .erase_error_flag, .status_program_error, .status_erase_error, .status_read_active,
        .ram_resident_rewrite_mode, .rom_resident_rewrite_mode, .maskable_irq_allowed
    );
    cpu_bus_model host (.clk, .rom_wr, .rom_rd, .rom_addr, .rom_wdata, .rom_rdata, .rom_rvalid);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----
    // Checks and reference model
    // ----
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic flags(string n);
        @(posedge clk);
        #1;
        chk({n, " flags"}, {m_stat, m_eerr, m_perr},
            {status_read_active, erase_error_flag, program_error_flag});
        chk({n, " mirror"}, {m_eerr, m_perr}, {status_erase_error, status_program_error});
        $display("test %s done", n);
    endtask

    function automatic logic [7:0] rexp(int x);
        return m_stat ? {1'b1, 1'b0, m_eerr, m_perr, 4'h0} : m_mem[x];
    endfunction

    task automatic rchk(string n, int x);
        logic [7:0] d;
        logic       v;
        host.rd(x[11:0], d, v);
        chk({n, " rvalid"}, 1, v);
        chk(n, rexp(x), d);
    endtask

    function automatic bit blk_ok(int x);
        return (x >> 10) == 0 ? low_block_master_unlock && !block_zero_lock
             : (x >> 10) == 1 && !block_one_lock;
    endfunction

    task automatic cmd(int x, logic [7:0] c);
        host.wr(x[11:0], c);
        if (cpu_rewrite_enable)
            case (c)
                CMD_READ_ARRAY:   m_stat = 1'b0;
                CMD_READ_STATUS:  m_stat = 1'b1;
                CMD_CLEAR_STATUS: {m_perr, m_eerr} = 2'b00;
                default:          {m_perr, m_eerr} = 2'b11;
            endcase
    endtask

    task automatic op(int x, logic [7:0] c, logic [7:0] d);
        int n;
        host.wr(12'h000, c);
        host.wr(x[11:0], d);
        if (c == CMD_ERASE && d == CMD_READ_ARRAY)
            m_stat = 1'b0;
        else if (!blk_ok(x) || (c == CMD_ERASE && d != CMD_ERASE_CONFIRM))
            {m_perr, m_eerr} = 2'b11;
        else
        begin
            m_stat = m_stat | !rom_resident_mode_select;
            flags("op start");
            chk("busy", 0, flash_ready_flag);
            chk("irq", !rom_resident_mode_select, maskable_irq_allowed);
            n = 0;
            while (flash_ready_flag !== 1'b1 && n < 3000)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            chk("ready", 1, flash_ready_flag);
            if (c == CMD_PROGRAM)
                m_mem[x] = m_mem[x] & d;
            else
                for (int i = 0; i < 1024; i++)
                    m_mem[(x >> 10 << 10) + i] = ERASED_BYTE;
        end
        flags("op end");
    endtask

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #200000;
        mismatches++;
        $display("watchdog expired");
        give_verdict();
    end

    // ----
    // Main sequence
    // ----
    initial
    begin
        {mismatches, checked} = 0;
        {rst, m_stat, m_perr, m_eerr} = 4'h8;
        {cpu_rewrite_enable, low_block_master_unlock, rom_resident_mode_select} = 3'h0;
        {block_zero_lock, block_one_lock} = 2'h0;
        void'($urandom(32'h06D8));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        flags("reset");
        cmd(12'h400, CMD_READ_STATUS);
        flags("disabled");
        @(posedge clk) cpu_rewrite_enable <= 1'b1;
        cmd(12'h7FF, CMD_READ_STATUS);
        rchk("status", 12'h400);
        rchk("status again", 12'h012);
        op(12'h5A0, CMD_ERASE, CMD_ERASE_CONFIRM);
        rchk("status after erase", 12'h5A0);
        cmd(12'h400, CMD_READ_ARRAY);
        rchk("erased", 12'h433);
        // each address fresh since the erase
        for (int k = 0; k < 4; k++)
        begin
            a = 12'h400 + k * 200 + int'($urandom_range(0, 199));
            op(a, CMD_PROGRAM, 8'($urandom));
            cmd(a, CMD_READ_ARRAY);
            rchk("program", a);
        end
        cmd(12'h000, 8'h11);
        flags("bad command");
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clk) {low_block_master_unlock, block_zero_lock, block_one_lock} <= ccfg[k];
            cmd(12'h000, CMD_READ_STATUS);
            op(cad[k], ccmd[k], cdat[k]);
            cmd(12'h000, CMD_CLEAR_STATUS);
            flags("clear");
        end
        op(12'h0C0, CMD_ERASE, CMD_ERASE_CONFIRM);
        op(12'h0C4, CMD_PROGRAM, 8'h5A);
        op(12'h400, CMD_ERASE, CMD_READ_ARRAY);
        rchk("block zero", 12'h0C4);
        chk("ram mode", 1, ram_resident_rewrite_mode);
        // select raised with enable already set
        @(posedge clk) rom_resident_mode_select <= 1'b1;
        flags("rom mode");
        chk("rom mode", 2, {rom_resident_rewrite_mode, ram_resident_rewrite_mode});
        // no status command, code area spared
        op(12'h7F0, CMD_PROGRAM, 8'($urandom));
        rchk("rom program", 12'h7F0);
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: flash_seq_pkg.sv */
package flash_seq_pkg;

    // ------
    // Command bytes
    // ------
    localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
    localparam logic [7:0] CMD_PROGRAM       = 8'h40;
    localparam logic [7:0] CMD_ERASE         = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] ERASED_BYTE       = 8'hFF;

    // ------
    // Status byte layout
    // ------
    localparam int SR_READY_BIT     = 7;
    localparam int SR_ERASE_ERR_BIT = 5;
    localparam int SR_PROG_ERR_BIT  = 4;

    // ------
    // Geometry and reset values
    // ------
    localparam int   ADDR_W_DEF    = 12;
    localparam int   BLK_W_DEF     = 10;
    localparam int   NUM_BLK_DEF   = 2;
    localparam int   CNT_W         = 24;
    localparam logic READY_RST     = 1'b1;
    localparam logic ERR_RST       = 1'b0;
    localparam int   RD_LATENCY    = 2;

    // ------
    // Timing
    // ------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int PROG_TIME_NS     = 50000;
    localparam int ERASE_TIME_NS    = 200000;
    localparam int PROG_CYCLES_DEF  = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES_DEF = ERASE_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PROG_WAIT,
        ST_ERASE_WAIT,
        ST_PROG_RUN,
        ST_ERASE_RUN,
        ST_VERIFY_WAIT,
        ST_VERIFY
    } seq_state_t;

    typedef enum logic {
        RM_ARRAY,
        RM_STATUS
    } read_mode_t;

endpackage

/* File: op_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module op_timer #(
    parameter int CNT_W = 24
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] cycles,
    output logic                  busy
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    always_comb
    begin
        cnt_d = cnt_q;
        if (start)
            cnt_d = cycles;
        else if (cnt_q != '0)
            cnt_d = cnt_q - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    assign busy = (cnt_q != '0);
endmodule
`default_nettype wire
